// ---- hw/vcrcr_pkg.sv ----
package vcrcr_pkg;
    localparam int         ADDR_W           = 12;
    localparam logic [11:0] VC0_CAP_OFFSET  = 12'h210;
    localparam logic [11:0] VC0_CTL_OFFSET  = 12'h214;

    localparam int ARB_CAP_LSB    = 0;
    localparam int ARB_CAP_W      = 8;
    localparam int ADV_PKT_BIT    = 14;
    localparam int REJ_SNOOP_BIT  = 15;
    localparam int MAX_TS_LSB     = 16;
    localparam int MAX_TS_W       = 7;
    localparam int TBL_OFF_LSB    = 24;
    localparam int TBL_OFF_W      = 8;
    localparam int TC_MAP_LSB     = 0;
    localparam int TC_MAP_W       = 8;

    // Scheme flags within the arbitration capability field
    localparam int ARB_FIXED_RR   = 0;
    localparam int ARB_WRR32      = 1;
    localparam int ARB_WRR64      = 2;
    localparam int ARB_WRR128     = 3;
    localparam int ARB_TWRR128    = 4;
    localparam int ARB_WRR256     = 5;

    localparam logic [7:0] ARB_CAP_UP     = 8'h03;
    localparam logic [7:0] ARB_CAP_DOWN   = 8'h01;
    localparam logic [7:0] TBL_OFF_UP     = 8'h02;
    localparam logic [7:0] TBL_OFF_DOWN   = 8'h00;
    localparam int         TBL_UNIT_BYTES = 16;
    localparam logic [6:0] MAX_TS_VALUE   = 7'h00;
    localparam logic       ADV_PKT_VALUE  = 1'b0;
    localparam logic       REJ_SN_VALUE   = 1'b0;
    localparam logic [7:0] TC_MAP_RESET   = 8'hff;
    localparam logic [7:0] TC_MAP_WR_MASK = 8'hfe;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ---- hw/vcrcr_regs.sv ----
`timescale 1ns/100ps
module vcrcr_regs (
    input  wire logic        core_clk,     // 200 MHz configuration clock
    input  wire logic        reset,        // Asynchronous, active high
    input  wire logic        portIsUp,     // Strap: high on the upstream port
    input  wire logic [11:0] wb_adr_i,     // Byte address
    input  wire logic [31:0] wb_dat_i,     // Write data
    input  wire logic [3:0]  wb_sel_i,     // Byte lane selects
    input  wire logic        wb_we_i,      // Write enable
    input  wire logic        wb_cyc_i,     // Bus cycle
    input  wire logic        wb_stb_i,     // Strobe
    output logic      [31:0] wb_dat_o,     // Read data
    output logic             wb_ack_o,     // Acknowledge
    output logic      [7:0]  tcRouteVc0,   // Traffic classes routed onto VC0
    output logic             arbTableHere  // Port arbitration table present
);
    logic        upstream_q;
    logic        strapTaken_q;
    logic [7:0]  tcMap_q;
    logic        ack_q;
    logic [31:0] rdData_q;
    logic [7:0]  tcRoute_q;
    logic        tblHere_q;
    logic        reqNew;
    logic        hitCap;
    logic        hitCtl;
    logic        capRead;
    logic        ctlRead;
    logic        ctlWrite;

    function automatic logic [31:0] capWord(input logic up);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[vcrcr_pkg::ARB_CAP_LSB +: vcrcr_pkg::ARB_CAP_W] =
            up ? vcrcr_pkg::ARB_CAP_UP : vcrcr_pkg::ARB_CAP_DOWN;
        w[vcrcr_pkg::ADV_PKT_BIT]   = vcrcr_pkg::ADV_PKT_VALUE;
        w[vcrcr_pkg::REJ_SNOOP_BIT] = vcrcr_pkg::REJ_SN_VALUE;
        w[vcrcr_pkg::MAX_TS_LSB +: vcrcr_pkg::MAX_TS_W] = vcrcr_pkg::MAX_TS_VALUE;
        w[vcrcr_pkg::TBL_OFF_LSB +: vcrcr_pkg::TBL_OFF_W] =
            up ? vcrcr_pkg::TBL_OFF_UP : vcrcr_pkg::TBL_OFF_DOWN;
        return w;
    endfunction

    function automatic logic [31:0] ctlWord(input logic [7:0] map);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[vcrcr_pkg::TC_MAP_LSB +: vcrcr_pkg::TC_MAP_W] = map;
        return w;
    endfunction

    assign reqNew = wb_cyc_i && wb_stb_i && !ack_q;
    assign hitCap = wb_adr_i[11:2] == vcrcr_pkg::VC0_CAP_OFFSET[11:2];
    assign hitCtl = wb_adr_i[11:2] == vcrcr_pkg::VC0_CTL_OFFSET[11:2];

    // Decoded request kinds, shared by the checks at the bottom
    assign capRead  = reqNew && !wb_we_i && hitCap;
    assign ctlRead  = reqNew && !wb_we_i && hitCtl;
    assign ctlWrite = reqNew && wb_we_i && hitCtl && wb_sel_i[0];

    // The strap is caught once, on the first edge after reset release
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            upstream_q   <= 1'b0;
            strapTaken_q <= 1'b0;
        end else if (!strapTaken_q) begin
            upstream_q   <= portIsUp;
            strapTaken_q <= 1'b1;
        end
    end

    // Bit 0 stays set: TC0 always rides VC0
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tcMap_q <= vcrcr_pkg::TC_MAP_RESET;
        end else if (reqNew && wb_we_i && hitCtl && wb_sel_i[0]) begin
            tcMap_q <= (wb_dat_i[7:0] & vcrcr_pkg::TC_MAP_WR_MASK)
                     | (vcrcr_pkg::TC_MAP_RESET & ~vcrcr_pkg::TC_MAP_WR_MASK);
        end
    end

    // Single-cycle answer; unmapped addresses still ack with zero data
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ack_q    <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end else begin
            ack_q <= reqNew;
            if (reqNew && !wb_we_i) begin
                if (hitCap) begin
                    rdData_q <= capWord(upstream_q);
                end else if (hitCtl) begin
                    rdData_q <= ctlWord(tcMap_q);
                end else begin
                    rdData_q <= vcrcr_pkg::UNMAPPED_DATA;
                end
            end
        end
    end

    // Only VC0 exists, so the map is the whole routing decision
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tcRoute_q <= vcrcr_pkg::TC_MAP_RESET;
            tblHere_q <= 1'b0;
        end else begin
            tcRoute_q <= tcMap_q;
            tblHere_q <= upstream_q;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdData_q;
    assign tcRouteVc0   = tcRoute_q;
    assign arbTableHere = tblHere_q;

    property p_arbCapValue;
        @(posedge core_clk) disable iff (reset)
        reqNew && !wb_we_i && hitCap |=> wb_ack_o &&
            wb_dat_o[7:0] == ($past(upstream_q) ? vcrcr_pkg::ARB_CAP_UP
                                                : vcrcr_pkg::ARB_CAP_DOWN);
    endproperty
    a_arbCapValue: assert property (p_arbCapValue) else $error("bad arbitration cap");

    property p_arbCapBits;
        @(posedge core_clk) disable iff (reset)
        reqNew && !wb_we_i && hitCap |=> wb_dat_o[0] && wb_dat_o[7:2] == 6'h00;
    endproperty
    a_arbCapBits: assert property (p_arbCapBits) else $error("bad scheme flags");

    property p_advPkt;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o && $past(hitCap && !wb_we_i) |-> !wb_dat_o[14];
    endproperty
    a_advPkt: assert property (p_advPkt) else $error("packet switching bit set");

    property p_rejSnoop;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o && $past(hitCap && !wb_we_i) |-> !wb_dat_o[15];
    endproperty
    a_rejSnoop: assert property (p_rejSnoop) else $error("reject snoop bit set");

    property p_max_time_slots;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o && $past(hitCap && !wb_we_i) |-> wb_dat_o[23:8] == 16'h0000;
    endproperty
    a_max_time_slots: assert property (p_max_time_slots) else $error("time slots nonzero");

    property p_tblOff;
        @(posedge core_clk) disable iff (reset)
        reqNew && !wb_we_i && hitCap |=>
            wb_dat_o[31:24] == ($past(upstream_q) ? vcrcr_pkg::TBL_OFF_UP
                                                  : vcrcr_pkg::TBL_OFF_DOWN);
    endproperty
    a_tblOff: assert property (p_tblOff) else $error("bad table offset");

    property p_tblFlag;
        @(posedge core_clk) disable iff (reset)
        strapTaken_q ##1 strapTaken_q |-> arbTableHere == upstream_q;
    endproperty
    a_tblFlag: assert property (p_tblFlag) else $error("table flag wrong");

    property p_mapBit0;
        @(posedge core_clk) disable iff (reset)
        tcMap_q[0] && tcRouteVc0[0];
    endproperty
    a_mapBit0: assert property (p_mapBit0) else $error("TC0 unmapped");

    property p_mapWrite;
        @(posedge core_clk) disable iff (reset)
        reqNew && wb_we_i && hitCtl && wb_sel_i[0] |=>
            tcMap_q[7:1] == $past(wb_dat_i[7:1]) ##1 tcRouteVc0[7:1] == $past(tcMap_q[7:1]);
    endproperty
    a_mapWrite: assert property (p_mapWrite) else $error("map write lost");

    property p_routeFollows;
        @(posedge core_clk) disable iff (reset)
        ##1 tcRouteVc0 == $past(tcMap_q);
    endproperty
    a_routeFollows: assert property (p_routeFollows) else $error("route lags map");

    property p_ignoreWrite;
        @(posedge core_clk) disable iff (reset)
        reqNew && (!wb_we_i || !hitCtl || !wb_sel_i[0]) |=> $stable(tcMap_q);
    endproperty
    a_ignoreWrite: assert property (p_ignoreWrite) else $error("stray write took");

    property p_ackPulse;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack held two cycles");

    // Capability word, split by port kind for the flags and the table offset
    property p_arbCapUp;
        @(posedge core_clk) disable iff (reset)
        capRead && upstream_q |=>
            wb_dat_o[vcrcr_pkg::ARB_CAP_LSB +: vcrcr_pkg::ARB_CAP_W] == vcrcr_pkg::ARB_CAP_UP;
    endproperty
    a_arbCapUp: assert property (p_arbCapUp) else $error("bad upstream flags");

    property p_arbCapDown;
        @(posedge core_clk) disable iff (reset)
        capRead && !upstream_q |=>
            wb_dat_o[vcrcr_pkg::ARB_CAP_LSB +: vcrcr_pkg::ARB_CAP_W] == vcrcr_pkg::ARB_CAP_DOWN;
    endproperty
    a_arbCapDown: assert property (p_arbCapDown) else $error("bad downstream flags");

    property p_strapCaught;
        @(posedge core_clk) disable iff (reset)
        $rose(strapTaken_q) |->
            upstream_q == $past(portIsUp);
    endproperty
    a_strapCaught: assert property (p_strapCaught) else $error("strap missed");

    property p_strapHeld;
        @(posedge core_clk) disable iff (reset)
        strapTaken_q |=>
            strapTaken_q && $stable(upstream_q);
    endproperty
    a_strapHeld: assert property (p_strapHeld) else $error("strap moved");

    property p_wrr32Flag;
        @(posedge core_clk) disable iff (reset)
        capRead |=>
            wb_dat_o[vcrcr_pkg::ARB_WRR32] == $past(upstream_q);
    endproperty
    a_wrr32Flag: assert property (p_wrr32Flag) else $error("bad 32-phase flag");

    property p_wideSchemes;
        @(posedge core_clk) disable iff (reset)
        capRead |=>
            !wb_dat_o[vcrcr_pkg::ARB_WRR64] && !wb_dat_o[vcrcr_pkg::ARB_WRR128] &&
            !wb_dat_o[vcrcr_pkg::ARB_TWRR128] && !wb_dat_o[vcrcr_pkg::ARB_WRR256] &&
            wb_dat_o[7:6] == 2'b00;
    endproperty
    a_wideSchemes: assert property (p_wideSchemes) else $error("unsupported scheme");

    property p_capReserved;
        @(posedge core_clk) disable iff (reset)
        capRead |=>
            wb_dat_o[13:8] == 6'h00 && !wb_dat_o[23];
    endproperty
    a_capReserved: assert property (p_capReserved) else $error("cap reserved set");

    property p_tblOffUp;
        @(posedge core_clk) disable iff (reset)
        capRead && upstream_q |=>
            wb_dat_o[vcrcr_pkg::TBL_OFF_LSB +: vcrcr_pkg::TBL_OFF_W] == vcrcr_pkg::TBL_OFF_UP;
    endproperty
    a_tblOffUp: assert property (p_tblOffUp) else $error("bad upstream offset");

    property p_tblOffDown;
        @(posedge core_clk) disable iff (reset)
        capRead && !upstream_q |=>
            wb_dat_o[vcrcr_pkg::TBL_OFF_LSB +: vcrcr_pkg::TBL_OFF_W] == vcrcr_pkg::TBL_OFF_DOWN;
    endproperty
    a_tblOffDown: assert property (p_tblOffDown) else $error("bad downstream offset");

    property p_tblMatchesWrr;
        @(posedge core_clk) disable iff (reset)
        capRead |=>
            (wb_dat_o[31:24] != 8'h00) == wb_dat_o[vcrcr_pkg::ARB_WRR32];
    endproperty
    a_tblMatchesWrr: assert property (p_tblMatchesWrr) else $error("offset mismatch");

    property p_tblFlagStable;
        @(posedge core_clk) disable iff (reset)
        strapTaken_q ##1 strapTaken_q |=>
            $stable(arbTableHere);
    endproperty
    a_tblFlagStable: assert property (p_tblFlagStable) else $error("table flag moved");

    property p_capWriteIgnored;
        @(posedge core_clk) disable iff (reset)
        reqNew && wb_we_i && hitCap |=>
            $stable(wb_dat_o) && $stable(tcMap_q);
    endproperty
    a_capWriteIgnored: assert property (p_capWriteIgnored) else $error("cap write took");

    // Control word and the map behind it
    property p_ctlReadMap;
        @(posedge core_clk) disable iff (reset)
        ctlRead |=>
            wb_dat_o[vcrcr_pkg::TC_MAP_LSB +: vcrcr_pkg::TC_MAP_W] == $past(tcMap_q);
    endproperty
    a_ctlReadMap: assert property (p_ctlReadMap) else $error("map read wrong");

    property p_ctlReadUpper;
        @(posedge core_clk) disable iff (reset)
        ctlRead |=>
            wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_ctlReadUpper: assert property (p_ctlReadUpper) else $error("upper ctl bits set");

    property p_routeMatchesRead;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o && $past(ctlRead) |->
            tcRouteVc0 == wb_dat_o[7:0];
    endproperty
    a_routeMatchesRead: assert property (p_routeMatchesRead) else $error("route off");

    property p_unmappedRead;
        @(posedge core_clk) disable iff (reset)
        reqNew && !wb_we_i && !hitCap && !hitCtl |=>
            wb_dat_o == vcrcr_pkg::UNMAPPED_DATA;
    endproperty
    a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped data");

    property p_mapOnlyByWrite;
        @(posedge core_clk) disable iff (reset)
        !ctlWrite |=>
            $stable(tcMap_q);
    endproperty
    a_mapOnlyByWrite: assert property (p_mapOnlyByWrite) else $error("map changed");

    property p_mapBit0Kept;
        @(posedge core_clk) disable iff (reset)
        ctlWrite && !wb_dat_i[0] |=>
            tcMap_q[0];
    endproperty
    a_mapBit0Kept: assert property (p_mapBit0Kept) else $error("map bit 0 cleared");

    // Handshake: read data stands until the next read is taken
    property p_datHolds;
        @(posedge core_clk) disable iff (reset)
        !(reqNew && !wb_we_i) |=>
            $stable(wb_dat_o);
    endproperty
    a_datHolds: assert property (p_datHolds) else $error("read data moved");

    property p_ackAfterReq;
        @(posedge core_clk) disable iff (reset)
        reqNew |=>
            wb_ack_o;
    endproperty
    a_ackAfterReq: assert property (p_ackAfterReq) else $error("ack missing");

    property p_ackNeedsReq;
        @(posedge core_clk) disable iff (reset)
        !reqNew |=>
            !wb_ack_o;
    endproperty
    a_ackNeedsReq: assert property (p_ackNeedsReq) else $error("ack unasked");

    property p_ackInCycle;
        @(posedge core_clk) disable iff (reset)
        wb_ack_o |->
            $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ackInCycle: assert property (p_ackInCycle) else $error("ack outside cycle");
endmodule // vcrcr_regs

// ---- bench/vcrcr_regs_test.sv ----
`timescale 1ns/100ps
module vcrcr_regs_test;
    logic        core_clk     = 1'b0;
    logic        reset        = 1'b1;
    logic        portIsUp     = 1'b1;
    logic [11:0] wbAdr        = 12'h000;
    logic [31:0] wbDatW       = 32'h0000_0000;
    logic [3:0]  wbSel        = 4'h0;
    logic        wbWe         = 1'b0;
    logic        wbCyc        = 1'b0;
    logic        wbStb        = 1'b0;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [7:0]  tcRouteVc0;
    logic        arbTableHere;
    logic [31:0] rd;
    logic [7:0]  mapExp;
    int          n_errors     = 0;
    int          n_checks     = 0;
    integer      seed         = 32'h6a9dd0df;

    vcrcr_regs uut (.core_clk(core_clk), .reset(reset), .portIsUp(portIsUp), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .tcRouteVc0(tcRouteVc0),
        .arbTableHere(arbTableHere));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle; waits on ack as long as it takes, the watchdog ends a dead run
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel);
        int n;
        @(posedge core_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbDatW <= dat;
        wbSel  <= sel;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1);
        // Answer comes one edge after the edge that takes the request
        check("ack latency", 32'h2, 32'(n));
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
        @(posedge core_clk);
    endtask

    function automatic logic [31:0] capExp(input logic up);
        return up ? {8'h02, 1'b0, 7'h00, 1'b0, 1'b0, 6'h00, 8'h03}
                  : {8'h00, 1'b0, 7'h00, 1'b0, 1'b0, 6'h00, 8'h01};
    endfunction

    initial begin
        for (int p = 0; p < 2; p++) begin
            reset    <= 1'b1;
            portIsUp <= (p == 0);
            repeat (8) @(posedge core_clk);
            reset <= 1'b0;
            // Strap lands on edge one, table flag on edge two: look on edge three
            repeat (3) @(posedge core_clk);
            check("arbTableHere", {31'h0, p == 0}, {31'h0, arbTableHere});
            check("tcRouteVc0 reset", 32'hff, {24'h0, tcRouteVc0});
            wb(1'b0, 12'h214, 32'h0, 4'h0);
            check("ctl reset", 32'h0000_00ff, rd);
            wb(1'b0, 12'h210, 32'h0, 4'h0);
            check("cap", capExp(p == 0), rd);
            wb(1'b1, 12'h210, $random(seed), 4'hf);
            wb(1'b0, 12'h210, 32'h0, 4'h0);
            check("cap after write", capExp(p == 0), rd);
            wb(1'b1, 12'h3fc, 32'hffff_ffff, 4'hf);
            wb(1'b0, 12'h3fc, 32'h0, 4'h0);
            check("unmapped read", 32'h0, rd);
            wb(1'b0, 12'h214, 32'h0, 4'h0);
            check("ctl after stray writes", 32'h0000_00ff, rd);
            mapExp = 8'hff;
            for (int i = 0; i < 40; i++) begin
                logic [31:0] d;
                logic [3:0]  s;
                d = (i == 0) ? 32'hffff_ff00 : $random(seed);
                s = (i == 0) ? 4'h1 : 4'($random(seed));
                wb(1'b1, 12'h214, d, s);
                if (s[0]) begin
                    mapExp = d[7:0] | 8'h01;
                end
                wb(1'b0, 12'h214, 32'h0, 4'h0);
                check("ctl", {24'h0, mapExp}, rd);
                check("tcRouteVc0", {24'h0, mapExp}, {24'h0, tcRouteVc0});
            end
        end
        end_of_test();
    end

    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
endmodule // vcrcr_regs_test
